// File: rtl/gpbcd_top.sv
/*
 * gpbcd_top: I/O register block for ports B, C and D on the CPU register port.
 * Assumes a one-cycle write or read strobe with address; pins arrive asynchronously.
 */
`timescale 1ns/1ps
module gpbcd_top #(
	parameter int W = gpbcd_pkg::PORT_W
) (
	input  wire logic                         SYS_CLK,
	input  wire logic                         RST_N,
	input  wire logic [gpbcd_pkg::ADDR_W-1:0] ADDR,
	input  wire logic                         SHORT_IO,
	input  wire logic                         WR_EN,
	input  wire logic                         RD_EN,
	input  wire logic [W-1:0]                 WDATA,
	input  wire logic                         GLOBAL_PULLUP_DISABLE,
	input  wire logic [W-1:0]                 PB_IN,
	input  wire logic [W-1:0]                 PC_IN,
	input  wire logic [W-1:0]                 PD_IN,
	output logic      [W-1:0]                 RDATA,
	output logic                              HIT,
	output logic      [W-1:0]                 PB_OUT,
	output logic      [W-1:0]                 PB_OE,
	output logic      [W-1:0]                 PB_PULLUP,
	output logic      [W-1:0]                 PC_OUT,
	output logic      [W-1:0]                 PC_OE,
	output logic      [W-1:0]                 PC_PULLUP,
	output logic      [W-1:0]                 PD_OUT,
	output logic      [W-1:0]                 PD_OE,
	output logic      [W-1:0]                 PD_PULLUP
);
	logic [W-1:0] pb_s1_reg;
	logic [W-1:0] pb_s2_reg;
	logic [W-1:0] pc_s1_reg;
	logic [W-1:0] pc_s2_reg;
	logic [W-1:0] pd_s1_reg;
	logic [W-1:0] pd_s2_reg;
	logic         pu_dis_s1_reg;
	logic         pu_dis_s2_reg;
	logic [W-1:0] rdata_reg;
	logic [W-1:0] rdata_next;
	logic         hit_reg;
	logic         hit_next;
	logic [7:0]   eff_addr;
	logic         short_ok;
	logic         sel_b_pin;
	logic         sel_b_dir;
	logic         sel_b_data;
	logic         sel_c_pin;
	logic         sel_c_dir;
	logic         sel_c_data;
	logic         sel_d_pin;
	logic         sel_d_dir;
	logic         sel_d_data;
	logic         any_sel;
	logic [W-1:0] b_dir;
	logic [W-1:0] b_data;
	logic [W-1:0] c_dir;
	logic [W-1:0] c_data;
	logic [W-1:0] d_dir;
	logic [W-1:0] d_data;

	// short I/O space is 0x00..0x3F, mapped up by 0x20; extended region unreachable
	assign short_ok = (ADDR <= gpbcd_pkg::IO_SHORT_MAX);
	assign eff_addr = SHORT_IO ? (ADDR + gpbcd_pkg::IO_SHORT_OFFS) : ADDR;
	// short access beyond 0x3F never decodes, so 0x60 and up need load/store
	assign any_sel  = !SHORT_IO || short_ok;

	assign sel_b_pin  = any_sel && (eff_addr == gpbcd_pkg::OFFS_B_PIN);
	assign sel_b_dir  = any_sel && (eff_addr == gpbcd_pkg::OFFS_B_DIR);
	assign sel_b_data = any_sel && (eff_addr == gpbcd_pkg::OFFS_B_DATA);
	assign sel_c_pin  = any_sel && (eff_addr == gpbcd_pkg::OFFS_C_PIN);
	assign sel_c_dir  = any_sel && (eff_addr == gpbcd_pkg::OFFS_C_DIR);
	assign sel_c_data = any_sel && (eff_addr == gpbcd_pkg::OFFS_C_DATA);
	assign sel_d_pin  = any_sel && (eff_addr == gpbcd_pkg::OFFS_D_PIN);
	assign sel_d_dir  = any_sel && (eff_addr == gpbcd_pkg::OFFS_D_DIR);
	assign sel_d_data = any_sel && (eff_addr == gpbcd_pkg::OFFS_D_DATA);

	assign hit_next = sel_b_pin || sel_b_dir || sel_b_data || sel_c_pin || sel_c_dir
	               || sel_c_data || sel_d_pin || sel_d_dir || sel_d_data;

	// pin registers read synchronised pad levels
	assign rdata_next = !RD_EN     ? rdata_reg :
	                    sel_b_pin  ? pb_s2_reg :
	                    sel_b_dir  ? b_dir :
	                    sel_b_data ? b_data :
	                    sel_c_pin  ? pc_s2_reg :
	                    sel_c_dir  ? c_dir :
	                    sel_c_data ? c_data :
	                    sel_d_pin  ? pd_s2_reg :
	                    sel_d_dir  ? d_dir :
	                    sel_d_data ? d_data : gpbcd_pkg::RD_UNMAPPED;

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			pb_s1_reg  <= '0;
			pb_s2_reg  <= '0;
			pc_s1_reg  <= '0;
			pc_s2_reg  <= '0;
			pd_s1_reg  <= '0;
			pd_s2_reg  <= '0;
			pu_dis_s1_reg <= 1'b0;
			pu_dis_s2_reg <= 1'b0;
			rdata_reg  <= gpbcd_pkg::RD_UNMAPPED;
			hit_reg    <= 1'b0;
		end
		else
		begin
			pb_s1_reg  <= PB_IN;
			pb_s2_reg  <= pb_s1_reg;
			pc_s1_reg  <= PC_IN;
			pc_s2_reg  <= pc_s1_reg;
			pd_s1_reg  <= PD_IN;
			pd_s2_reg  <= pd_s1_reg;
			pu_dis_s1_reg <= GLOBAL_PULLUP_DISABLE;
			pu_dis_s2_reg <= pu_dis_s1_reg;
			rdata_reg  <= rdata_next;
			hit_reg    <= (RD_EN || WR_EN) && hit_next;
		end
	end

	assign RDATA = rdata_reg;
	assign HIT   = hit_reg;

	gpbcd_port #(.W(W)) u_port_b (
		.clk            (SYS_CLK),
		.rst_n          (RST_N),
		.dir_we         (WR_EN && sel_b_dir),
		.data_we        (WR_EN && sel_b_data),
		.pin_we         (WR_EN && sel_b_pin),
		.wdata          (WDATA),
		.pullup_disable (pu_dis_s2_reg),
		.pin_sync       (pb_s2_reg),
		.dir_q          (b_dir),
		.data_q         (b_data),
		.pad_out        (PB_OUT),
		.pad_oe         (PB_OE),
		.pullup_en      (PB_PULLUP)
	);

	gpbcd_port #(.W(W)) u_port_c (
		.clk            (SYS_CLK),
		.rst_n          (RST_N),
		.dir_we         (WR_EN && sel_c_dir),
		.data_we        (WR_EN && sel_c_data),
		.pin_we         (WR_EN && sel_c_pin),
		.wdata          (WDATA),
		.pullup_disable (pu_dis_s2_reg),
		.pin_sync       (pc_s2_reg),
		.dir_q          (c_dir),
		.data_q         (c_data),
		.pad_out        (PC_OUT),
		.pad_oe         (PC_OE),
		.pullup_en      (PC_PULLUP)
	);

	gpbcd_port #(.W(W)) u_port_d (
		.clk            (SYS_CLK),
		.rst_n          (RST_N),
		.dir_we         (WR_EN && sel_d_dir),
		.data_we        (WR_EN && sel_d_data),
		.pin_we         (WR_EN && sel_d_pin),
		.wdata          (WDATA),
		.pullup_disable (pu_dis_s2_reg),
		.pin_sync       (pd_s2_reg),
		.dir_q          (d_dir),
		.data_q         (d_data),
		.pad_out        (PD_OUT),
		.pad_oe         (PD_OE),
		.pullup_en      (PD_PULLUP)
	);

	sequence s_short_wr_b_dir;
		WR_EN && SHORT_IO && ADDR == 8'h04;
	endsequence
	property p_short_decode;
		@(posedge SYS_CLK) disable iff (!RST_N)
		s_short_wr_b_dir |=> b_dir == $past(WDATA) && PB_OE == $past(WDATA);
	endproperty
	a_short_decode: assert property (p_short_decode) else $error("short address miss");

	property p_ext_short_refused;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(WR_EN || RD_EN) && SHORT_IO && ADDR > 8'h3F |=> !HIT;
	endproperty
	a_ext_short_refused: assert property (p_ext_short_refused) else $error("short hit above 0x3F");

	property p_d_data_write;
		@(posedge SYS_CLK) disable iff (!RST_N)
		WR_EN && !SHORT_IO && ADDR == 8'h2B |=> d_data == $past(WDATA) && HIT;
	endproperty
	a_d_data_write: assert property (p_d_data_write) else $error("port d data write lost");

	property p_c_dir_readback;
		@(posedge SYS_CLK) disable iff (!RST_N)
		RD_EN && !WR_EN && SHORT_IO && ADDR == 8'h07 |=> RDATA == $past(c_dir);
	endproperty
	a_c_dir_readback: assert property (p_c_dir_readback) else $error("dir readback wrong");

	property p_reset_zero;
		@(posedge SYS_CLK)
		!RST_N |=> b_dir == 8'h00 && c_data == 8'h00 && d_dir == 8'h00 && PC_OE == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

	property p_pin_read;
		@(posedge SYS_CLK) disable iff (!RST_N)
		RD_EN && !SHORT_IO && ADDR == 8'h29 |=> RDATA == $past(pd_s2_reg);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

	property p_c_toggle;
		@(posedge SYS_CLK) disable iff (!RST_N)
		WR_EN && !SHORT_IO && ADDR == 8'h26 |=> c_data == ($past(c_data) ^ $past(WDATA));
	endproperty
	a_c_toggle: assert property (p_c_toggle) else $error("port c toggle wrong");

	property p_unmapped;
		@(posedge SYS_CLK) disable iff (!RST_N)
		RD_EN && !SHORT_IO && ADDR == 8'h60 |=> RDATA == 8'h00 && !HIT;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // gpbcd_top

// File: shared/gpbcd_pkg.sv
/*
 * gpbcd_pkg: register map, reset values and widths of the port B/C/D register block.
 * Assumes the CPU presents data-space addresses; short I/O addresses sit 0x20 lower.
 */
package gpbcd_pkg;
	localparam int          PORT_W        = 8;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  IO_SHORT_OFFS = 8'h20;
	localparam logic [7:0]  IO_SHORT_MAX  = 8'h3F;
	localparam logic [7:0]  EXT_IO_BASE   = 8'h60;
	localparam logic [7:0]  OFFS_B_PIN    = 8'h23;
	localparam logic [7:0]  OFFS_B_DIR    = 8'h24;
	localparam logic [7:0]  OFFS_B_DATA   = 8'h25;
	localparam logic [7:0]  OFFS_C_PIN    = 8'h26;
	localparam logic [7:0]  OFFS_C_DIR    = 8'h27;
	localparam logic [7:0]  OFFS_C_DATA   = 8'h28;
	localparam logic [7:0]  OFFS_D_PIN    = 8'h29;
	localparam logic [7:0]  OFFS_D_DIR    = 8'h2A;
	localparam logic [7:0]  OFFS_D_DATA   = 8'h2B;
	localparam logic [7:0]  RST_DIR       = 8'h00;
	localparam logic [7:0]  RST_DATA      = 8'h00;
	localparam logic [7:0]  RD_UNMAPPED   = 8'h00;
endpackage

// File: rtl/gpbcd_port.sv
/*
 * gpbcd_port: one 8-bit port with data, direction and pin-toggle registers.
 * Assumes strobes are one-cycle pulses from the decoder in the same clock domain.
 */
`timescale 1ns/1ps
module gpbcd_port #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         dir_we,
	input  wire logic         data_we,
	input  wire logic         pin_we,
	input  wire logic [W-1:0] wdata,
	input  wire logic         pullup_disable,
	input  wire logic [W-1:0] pin_sync,
	output logic      [W-1:0] dir_q,
	output logic      [W-1:0] data_q,
	output logic      [W-1:0] pad_out,
	output logic      [W-1:0] pad_oe,
	output logic      [W-1:0] pullup_en
);
	logic [W-1:0] dir_reg;
	logic [W-1:0] dir_next;
	logic [W-1:0] data_reg;
	logic [W-1:0] data_next;
	logic [W-1:0] out_reg;
	logic [W-1:0] oe_reg;
	logic [W-1:0] pu_reg;
	logic [W-1:0] pu_next;

	// direction store, each bit on its own
	assign dir_next  = dir_we ? wdata : dir_reg;
	// pin-register write flips written ones, data write stores
	assign data_next = pin_we ? (data_reg ^ wdata) :
	                   (data_we ? wdata : data_reg);
	assign pu_next   = pullup_disable ? {W{1'b0}} : (~dir_next & data_next);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dir_reg  <= gpbcd_pkg::RST_DIR;
			data_reg <= gpbcd_pkg::RST_DATA;
			out_reg  <= gpbcd_pkg::RST_DATA;
			oe_reg   <= gpbcd_pkg::RST_DIR;
			pu_reg   <= {W{1'b0}};
		end
		else
		begin
			dir_reg  <= dir_next;
			data_reg <= data_next;
			out_reg  <= data_next;
			oe_reg   <= dir_next;
			pu_reg   <= pu_next;
		end
	end

	assign dir_q     = dir_reg;
	assign data_q    = data_reg;
	assign pad_out   = out_reg;
	assign pad_oe    = oe_reg;
	assign pullup_en = pu_reg;

	property p_toggle;
		@(posedge clk) disable iff (!rst_n)
		pin_we |=> data_reg == ($past(data_reg) ^ $past(wdata));
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin write did not toggle");

	property p_oe_follows_dir;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> pad_oe == dir_reg && pad_out == data_reg;
	endproperty
	a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("pad drive wrong");

	property p_pullup;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> pullup_en == ($past(pullup_disable) ? '0 : (~dir_reg & data_reg));
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");
endmodule // gpbcd_port

// File: dv/gpbcd_cpu_model.sv
/*
 * gpbcd_cpu_model: CPU side making single byte loads, stores or short I/O accesses.
 * Assumes the register block shares its clock; one access at a time.
 */
`timescale 1ns/1ps
module gpbcd_cpu_model (
	input  wire logic       clk,
	output logic      [7:0] addr,
	output logic            short_io,
	output logic            wr_en,
	output logic            rd_en,
	output logic      [7:0] wdata,
	input  wire logic [7:0] rdata,
	input  wire logic       hit
);
	initial
	begin
		addr = 8'h00;
		short_io = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = 8'h00;
	end

	// raw cycle: request after one edge, taken at the next, answer read mid-cycle
	task automatic bus_cycle(input logic [7:0] a, input logic s, input logic w,
		input logic [7:0] d, output logic [7:0] q, output logic h);
		@(posedge clk);
		addr <= a;
		short_io <= s;
		wr_en <= w;
		rd_en <= !w;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		@(negedge clk);
		q = rdata;
		h = hit;
	endtask

	// a is a data-space address; short form only below the extended region
	task automatic access(input logic [7:0] a, input logic s, input logic w,
		input logic [7:0] d, output logic [7:0] q, output logic h);
		logic sh;
		sh = s && (a < gpbcd_pkg::EXT_IO_BASE);
		bus_cycle(sh ? a - gpbcd_pkg::IO_SHORT_OFFS : a, sh, w, d, q, h);
	endtask
endmodule // gpbcd_cpu_model

// File: dv/tb_gpio_port_regs_bcd.sv
/*
 * tb_gpio_port_regs_bcd: random and corner accesses to the port B/C/D registers.
 * Assumes the CPU model as bus master and pads driven here.
 */
`timescale 1ns/1ps
module tb_gpio_port_regs_bcd;
	logic       SYS_CLK = 1'b0;
	logic       RST_N = 1'b0;
	logic       GLOBAL_PULLUP_DISABLE = 1'b0;
	logic [7:0] PB_IN = 8'h00;
	logic [7:0] PC_IN = 8'h00;
	logic [7:0] PD_IN = 8'h00;
	wire  [7:0] ADDR, WDATA, RDATA;
	wire        SHORT_IO, WR_EN, RD_EN, HIT;
	wire  [7:0] PB_OUT, PB_OE, PB_PULLUP, PC_OUT, PC_OE, PC_PULLUP, PD_OUT, PD_OE, PD_PULLUP;
	logic [7:0] oe_a[3], out_a[3], pu_a[3];
	logic [7:0] dir_m[3], dat_m[3], pin_m[3], q;
	logic       h;
	int         failures = 0, n_tests = 0, seed = 9, p, k, s;

	always #20 SYS_CLK = ~SYS_CLK;
	always_comb oe_a = '{PB_OE, PC_OE, PD_OE};
	always_comb out_a = '{PB_OUT, PC_OUT, PD_OUT};
	always_comb pu_a = '{PB_PULLUP, PC_PULLUP, PD_PULLUP};

	gpbcd_cpu_model cpu (.clk(SYS_CLK), .addr(ADDR), .short_io(SHORT_IO), .wr_en(WR_EN),
		.rd_en(RD_EN), .wdata(WDATA), .rdata(RDATA), .hit(HIT));
	gpbcd_top uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .SHORT_IO(SHORT_IO),
		.WR_EN(WR_EN), .RD_EN(RD_EN), .WDATA(WDATA),
		.GLOBAL_PULLUP_DISABLE(GLOBAL_PULLUP_DISABLE), .PB_IN(PB_IN), .PC_IN(PC_IN),
		.PD_IN(PD_IN), .RDATA(RDATA), .HIT(HIT), .PB_OUT(PB_OUT), .PB_OE(PB_OE),
		.PB_PULLUP(PB_PULLUP), .PC_OUT(PC_OUT), .PC_OE(PC_OE), .PC_PULLUP(PC_PULLUP),
		.PD_OUT(PD_OUT), .PD_OE(PD_OE), .PD_PULLUP(PD_PULLUP));

	// k: 0 pin, 1 direction, 2 data
	function automatic logic [7:0] reg_addr(input int p, input int k);
		return gpbcd_pkg::OFFS_B_PIN + 8'(3 * p + k);
	endfunction

	function automatic logic [7:0] exp_pu(input int p);
		return ~dir_m[p] & dat_m[p] & {8{~GLOBAL_PULLUP_DISABLE}};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wr(input int p, input int k, input int s, input logic [7:0] d);
		cpu.access(reg_addr(p, k), s[0], 1'b1, d, q, h);
		chk({7'h00, h}, 8'h01);
		if (k == 0)
			dat_m[p] = dat_m[p] ^ d;
		else if (k == 1)
			dir_m[p] = d;
		else
			dat_m[p] = d;
	endtask

	task automatic rdchk(input int p, input int k, input int s);
		cpu.access(reg_addr(p, k), s[0], 1'b0, 8'h00, q, h);
		chk({7'h00, h}, 8'h01);
		chk(q, k == 0 ? pin_m[p] : (k == 1 ? dir_m[p] : dat_m[p]));
	endtask

	// pads looked at mid-cycle, well after the last write settled
	task automatic pads(input int p);
		repeat (4) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		chk(oe_a[p], dir_m[p]);
		chk(out_a[p], dat_m[p]);
		chk(pu_a[p], exp_pu(p));
	endtask

	task automatic set_pins;
		for (int i = 0; i < 3; i++)
			pin_m[i] = 8'($random(seed));
		PB_IN <= pin_m[0];
		PC_IN <= pin_m[1];
		PD_IN <= pin_m[2];
	endtask

	initial
	begin
		dir_m = '{8'h00, 8'h00, 8'h00};
		dat_m = '{8'h00, 8'h00, 8'h00};
		pin_m = '{8'h00, 8'h00, 8'h00};
		repeat (12) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		for (p = 0; p < 3; p++)
		begin
			rdchk(p, 1, 0);
			rdchk(p, 2, 1);
			pads(p);
		end
		for (p = 0; p < 3; p++)
		begin
			wr(p, 1, 1, 8'hF0);
			wr(p, 2, 0, 8'hA5);
			wr(p, 0, 1, 8'hFF);
			pads(p);
			rdchk(p, 2, 0);
		end
		for (int n = 0; n < 300; n++)
		begin
			p = {$random(seed)} % 3;
			k = {$random(seed)} % 3;
			s = $random(seed);
			@(posedge SYS_CLK);
			GLOBAL_PULLUP_DISABLE <= 1'($random(seed));
			set_pins;
			wr(p, k, s, 8'($random(seed)));
			pads(p);
			rdchk(p, {$random(seed)} % 3, ~s);
		end
		// 0x20 and 0x40 lie outside the block, 0x60 is extended space
		foreach (pin_m[i])
		begin
			cpu.access(8'h20 + 8'(i * 32), 1'b0, 1'b1, 8'hFF, q, h);
			chk({7'h00, h}, 8'h00);
			cpu.access(8'h20 + 8'(i * 32), 1'b1, 1'b0, 8'h00, q, h);
			chk({7'h00, h}, 8'h00);
			chk(q, gpbcd_pkg::RD_UNMAPPED);
		end
		// short address above the short range must be refused
		cpu.bus_cycle(8'h44, 1'b1, 1'b1, 8'hFF, q, h);
		chk({7'h00, h}, 8'h00);
		cpu.bus_cycle(8'h44, 1'b1, 1'b0, 8'h00, q, h);
		chk({7'h00, h}, 8'h00);
		chk(q, gpbcd_pkg::RD_UNMAPPED);
		for (p = 0; p < 3; p++)
			pads(p);
		@(posedge SYS_CLK);
		RST_N <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(negedge SYS_CLK);
		chk(RDATA, gpbcd_pkg::RD_UNMAPPED);
		chk({7'h00, HIT}, 8'h00);
		dir_m = '{8'h00, 8'h00, 8'h00};
		dat_m = '{8'h00, 8'h00, 8'h00};
		for (p = 0; p < 3; p++)
			pads(p);
		conclude;
	end

	initial
	begin
		#800000;
		failures++;
		conclude;
	end
endmodule // tb_gpio_port_regs_bcd
